// ### swl_params.svh
// Constants for the single-wire register link host controller
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH

`define SWL_CLK_HZ          40000000
`define SWL_DEV_CLK_HZ      20000000
`define SWL_MIN_BAUD        9000
`define SWL_DEV_OVERSAMPLE  16
`define SWL_MIN_DIV         ((`SWL_CLK_HZ * `SWL_DEV_OVERSAMPLE + `SWL_DEV_CLK_HZ - 1) / `SWL_DEV_CLK_HZ)
`define SWL_MAX_DIV         (`SWL_CLK_HZ / `SWL_MIN_BAUD)
`define SWL_DROP_NUM        20
`define SWL_DROP_DEN        3

`define SWL_OFS_CTRL        8'h00
`define SWL_OFS_WDATA       8'h04
`define SWL_OFS_DIV         8'h08
`define SWL_OFS_STATUS      8'h0c
`define SWL_OFS_RDATA       8'h10
`define SWL_OFS_RADDR       8'h14
`define SWL_OFS_RTMO        8'h18

`define SWL_CTRL_GO         0
`define SWL_CTRL_WRITE      1
`define SWL_CTRL_NODE_LSB   8
`define SWL_CTRL_REG_LSB    16

`define SWL_ST_BUSY         0
`define SWL_ST_DONE         1
`define SWL_ST_CRC          2
`define SWL_ST_FRAME        3
`define SWL_ST_TMO          4
`define SWL_ST_HDR          5
`define SWL_ST_DIVREJ       6
`define SWL_ST_W            7

`define SWL_SYNC_BYTE       8'h05
`define SWL_SYNC_MASK       8'h0f
`define SWL_MASTER_ADDR     8'hff
`define SWL_CRC_POLY        8'h07
`define SWL_LEN_WRITE       4'd8
`define SWL_LEN_READ        4'd4
`define SWL_LEN_REPLY       4'd8
`define SWL_GAP_BITS        16'd63
`define SWL_IDLE_BITS       16'd13
`define SWL_DEF_RTMO        16'd160
`define SWL_FRAME_BITS      4'd9

`define SWL_RESP_OKAY       2'b00
`define SWL_RESP_SLVERR     2'b10

`endif

// ### swl_pkg.sv
// Types shared by the single-wire register link host controller
package swl_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {ST_IDLE, ST_GUARD, ST_SEND, ST_LISTEN} ctl_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : swl_pkg

// ### swl_byte_tx.sv
// Byte transmitter: start bit, eight data bits LSB first, stop bit
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_byte_tx #(
  parameter int DIV_W = 16
) (
  input  wire logic               mclk,    // System clock
  input  wire logic               arst_n,  // Async reset, active low
  input  wire logic [DIV_W-1:0]   div,     // Clocks per bit
  input  wire logic               go,      // Take byte when ready
  input  wire swl_pkg::byte_t     data,    // Byte to send
  output logic                    ready,   // Idle, can take a byte
  output logic                    line     // Serial output level
);
  logic [9:0]       shift;
  logic [3:0]       bitIdx;
  logic [DIV_W-1:0] timer;
  logic             busy;
  wire              bitEnd = (timer == DIV_W'(1));

  assign ready = ~busy;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy   <= 1'b0;
      shift  <= '1;
      bitIdx <= '0;
      timer  <= '0;
      line   <= 1'b1;
    end else if (!busy) begin
      line <= 1'b1;
      if (go) begin
        busy   <= 1'b1;
        shift  <= {1'b1, data, 1'b0};
        bitIdx <= '0;
        timer  <= div;
        line   <= 1'b0;
      end
    end else if (bitEnd) begin
      timer <= div;
      if (bitIdx == `SWL_FRAME_BITS) begin
        busy <= 1'b0;
      end else begin
        bitIdx <= bitIdx + 4'd1;
        line   <= shift[bitIdx + 4'd1];
      end
    end else begin
      timer <= timer - DIV_W'(1);
    end
  end
endmodule : swl_byte_tx

// ### swl_byte_rx.sv
// Byte receiver with mid-bit sampling and stop-bit check
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_byte_rx #(
  parameter int DIV_W = 16
) (
  input  wire logic               mclk,      // System clock
  input  wire logic               arst_n,    // Async reset, active low
  input  wire logic [DIV_W-1:0]   div,       // Clocks per bit
  input  wire logic               enable,    // Listen to the line
  input  wire logic               line,      // Synchronised line level
  output logic                    startSeen, // Pulse: valid start bit
  output logic                    byteValid, // Pulse: byte received
  output logic                    frameErr,  // Pulse: stop bit low
  output swl_pkg::byte_t          data       // Received byte
);
  swl_pkg::rx_state_e state;
  logic [DIV_W-1:0]   timer;
  logic [2:0]         bitIdx;
  wire                tick = (timer == '0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= swl_pkg::RX_IDLE;
      timer     <= '0;
      bitIdx    <= '0;
      data      <= '0;
      startSeen <= 1'b0;
      byteValid <= 1'b0;
      frameErr  <= 1'b0;
    end else begin
      startSeen <= 1'b0;
      byteValid <= 1'b0;
      frameErr  <= 1'b0;
      timer     <= tick ? div - DIV_W'(1) : timer - DIV_W'(1);
      case (state)
        swl_pkg::RX_IDLE: begin
          if (enable && !line) begin
            state <= swl_pkg::RX_START;
            timer <= div >> 1;
          end
        end
        swl_pkg::RX_START: begin
          if (tick) begin
            state     <= line ? swl_pkg::RX_IDLE : swl_pkg::RX_DATA;
            startSeen <= ~line;
            bitIdx    <= '0;
          end
        end
        swl_pkg::RX_DATA: begin
          if (tick) begin
            data   <= {line, data[7:1]};
            bitIdx <= bitIdx + 3'd1;
            if (bitIdx == 3'd7) begin
              state <= swl_pkg::RX_STOP;
            end
          end
        end
        swl_pkg::RX_STOP: begin
          if (tick) begin
            state     <= swl_pkg::RX_IDLE;
            byteValid <= line;
            frameErr  <= ~line;
          end
        end
        default: state <= swl_pkg::RX_IDLE;
      endcase
    end
  end
endmodule : swl_byte_rx

// ### swl_host.sv
// Host controller for a single-wire UART register link, AXI4-Lite programmed
// How it works
// - Datagrams open with sync byte 0x05, then node address 0 to 3.
// - Write datagram: sync, node, flag plus index, data MSB first, CRC.
// - Bytes framed by low start, high stop, data bits LSB first.
// - Host baud at least 9000 and at most device clock over 16.
// - Register byte bit 7 set means write, clear means read.
// - Gaps over 63 bit times reset; line idles 13 bit times before restart.
// - Host never drops baud below 15 percent of previous rate.
// - Line rests high; software disables the shared pin power-down function.
// - Read request: sync, node, cleared flag plus index, CRC.
// - With several slaves, software sets reply wait to at least 2.
// - CRC8 poly 0x07 from zero over all bytes, LSB first.
// - Host framing is 8 data bits, no parity.
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_host #(
  parameter int          DIV_W   = 16,
  parameter logic [15:0] DEF_DIV = 16'd347
) (
  input  wire logic        mclk,     // 40 MHz clock
  input  wire logic        arst_n,   // Async reset, active low
  input  wire logic [7:0]  awaddr,   // AXI write address
  input  wire logic        awvalid,  // AXI write address valid
  output logic             awready,  // AXI write address ready
  input  wire logic [31:0] wdata,    // AXI write data
  input  wire logic [3:0]  wstrb,    // AXI write strobes
  input  wire logic        wvalid,   // AXI write data valid
  output logic             wready,   // AXI write data ready
  output logic [1:0]       bresp,    // AXI write response
  output logic             bvalid,   // AXI write response valid
  input  wire logic        bready,   // AXI write response ready
  input  wire logic [7:0]  araddr,   // AXI read address
  input  wire logic        arvalid,  // AXI read address valid
  output logic             arready,  // AXI read address ready
  output logic [31:0]      rdata,    // AXI read data
  output logic [1:0]       rresp,    // AXI read response
  output logic             rvalid,   // AXI read data valid
  input  wire logic        rready,   // AXI read data ready
  input  wire logic        uartIn,   // Shared line, input level
  output logic             uartOut,  // Shared line, driven level
  output logic             uartOeN   // Shared line enable, low drives
);
  generate
    if (DIV_W < 13 || DEF_DIV < `SWL_MIN_DIV || DEF_DIV > `SWL_MAX_DIV) begin : g_bad
      $error("swl_host: divider width or default out of range");
    end
  endgenerate

  // CRC step over one byte, LSB first
  function automatic swl_pkg::byte_t crcStep(input swl_pkg::byte_t crc,
                                             input swl_pkg::byte_t b);
    swl_pkg::byte_t c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ `SWL_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crcStep

  // Byte merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Outgoing datagram byte by position
  function automatic swl_pkg::byte_t txByteAt(input logic [3:0] idx, input logic wr,
                                              input logic [1:0] node, input logic [6:0] reg7,
                                              input logic [31:0] d, input swl_pkg::byte_t crc);
    case (idx)
      4'd0:    return `SWL_SYNC_BYTE;
      4'd1:    return {6'h00, node};
      4'd2:    return {wr, reg7};
      4'd3:    return wr ? d[31:24] : crc;
      4'd4:    return d[23:16];
      4'd5:    return d[15:8];
      4'd6:    return d[7:0];
      default: return crc;
    endcase
  endfunction : txByteAt

  // Line input synchroniser
  logic lineMeta;
  logic lineSync;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lineMeta <= 1'b1;
      lineSync <= 1'b1;
    end else begin
      lineMeta <= uartIn;
      lineSync <= lineMeta;
    end
  end

  // Registers
  swl_pkg::ctl_state_e state;
  logic                    ctrlWrite;
  logic [1:0]              ctrlNode;
  logic [6:0]              ctrlReg;
  logic [31:0]             wdataReg;
  logic [DIV_W-1:0]        divReg;
  logic [15:0]             rtmoReg;
  logic [`SWL_ST_W-1:1]    status;
  logic [31:0]             rdataReg;
  swl_pkg::byte_t          raddrReg;

  // AXI write path: address and data taken together
  wire wrFire = awvalid & wvalid & ~bvalid;
  assign awready = ~bvalid & wvalid;
  assign wready  = ~bvalid & awvalid;

  wire hitCtrl   = (awaddr == `SWL_OFS_CTRL);
  wire hitWdata  = (awaddr == `SWL_OFS_WDATA);
  wire hitDiv    = (awaddr == `SWL_OFS_DIV);
  wire hitStatus = (awaddr == `SWL_OFS_STATUS);
  wire hitRtmo   = (awaddr == `SWL_OFS_RTMO);
  wire wrMapped  = hitCtrl | hitWdata | hitDiv | hitStatus | hitRtmo |
                   (awaddr == `SWL_OFS_RDATA) | (awaddr == `SWL_OFS_RADDR);

  wire [31:0] ctrlView = {9'h000, ctrlReg, 6'h00, ctrlNode, 6'h00, ctrlWrite, 1'b0};
  wire [31:0] ctrlNew  = merge(ctrlView, wdata, wstrb);
  wire [31:0] divNew   = merge({{(32-DIV_W){1'b0}}, divReg}, wdata, wstrb);
  wire        idle     = (state == swl_pkg::ST_IDLE);
  wire        goReq    = wrFire & hitCtrl & wstrb[0] & wdata[`SWL_CTRL_GO] & idle;

  // Divider bounds and no abrupt rate drop below 15 percent
  wire divInRange = (divNew >= 32'(`SWL_MIN_DIV)) && (divNew <= 32'(`SWL_MAX_DIV));
  wire divTooSlow = (divNew * 32'(`SWL_DROP_DEN)) >
                    (32'(divReg) * 32'(`SWL_DROP_NUM));
  wire divOk      = divInRange & ~divTooSlow & idle;
  wire divWrite   = wrFire & hitDiv & (|wstrb);
  wire [31:0] rtmoNew = merge({16'h0000, rtmoReg}, wdata, wstrb);

  // AXI read path
  logic [31:0] rdMux;
  wire         rdMapped = (araddr == `SWL_OFS_CTRL) | (araddr == `SWL_OFS_WDATA) |
                          (araddr == `SWL_OFS_DIV) | (araddr == `SWL_OFS_STATUS) |
                          (araddr == `SWL_OFS_RDATA) | (araddr == `SWL_OFS_RADDR) |
                          (araddr == `SWL_OFS_RTMO);
  assign arready = ~rvalid;
  always_comb begin
    case (araddr)
      `SWL_OFS_CTRL:   rdMux = ctrlView;
      `SWL_OFS_WDATA:  rdMux = wdataReg;
      `SWL_OFS_DIV:    rdMux = {{(32-DIV_W){1'b0}}, divReg};
      `SWL_OFS_STATUS: rdMux = {{(32-`SWL_ST_W){1'b0}}, status, ~idle};
      `SWL_OFS_RDATA:  rdMux = rdataReg;
      `SWL_OFS_RADDR:  rdMux = {24'h000000, raddrReg};
      `SWL_OFS_RTMO:   rdMux = {16'h0000, rtmoReg};
      default:         rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= `SWL_RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= `SWL_RESP_OKAY;
      rdata  <= '0;
    end else begin
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? `SWL_RESP_OKAY : `SWL_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rdata  <= rdMux;
        rresp  <= rdMapped ? `SWL_RESP_OKAY : `SWL_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Byte engines
  logic           txReady;
  logic           txLine;
  logic           rxStart;
  logic           rxValid;
  logic           rxFrameErr;
  swl_pkg::byte_t rxByte;
  logic [3:0]     txIdx;
  logic [3:0]     rxIdx;
  swl_pkg::byte_t crcAcc;

  wire [3:0]      txLen  = ctrlWrite ? `SWL_LEN_WRITE : `SWL_LEN_READ;
  wire            txGo   = (state == swl_pkg::ST_SEND) & txReady & (txIdx != txLen);
  wire swl_pkg::byte_t txByte = txByteAt(txIdx, ctrlWrite, ctrlNode, ctrlReg, wdataReg, crcAcc);

  swl_byte_tx #(.DIV_W(DIV_W)) u_tx (
    .mclk   (mclk),
    .arst_n (arst_n),
    .div    (divReg),
    .go     (txGo),
    .data   (txByte),
    .ready  (txReady),
    .line   (txLine)
  );

  swl_byte_rx #(.DIV_W(DIV_W)) u_rx (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .div       (divReg),
    .enable    (state == swl_pkg::ST_LISTEN),
    .line      (lineSync),
    .startSeen (rxStart),
    .byteValid (rxValid),
    .frameErr  (rxFrameErr),
    .data      (rxByte)
  );

  // Bit-time ticker for guard and timeouts
  logic [DIV_W-1:0] tickCnt;
  logic [15:0]      bitCnt;
  wire              tick    = (tickCnt == divReg - DIV_W'(1));
  wire              guardCl = (state == swl_pkg::ST_GUARD) & ~lineSync;
  wire [15:0]       waitLim = (rxIdx == 4'd0) ? rtmoReg : `SWL_GAP_BITS;

  // Reply checks
  wire lastRx  = rxValid & (rxIdx == `SWL_LEN_REPLY - 4'd1);
  wire hdrBad  = ((rxIdx == 4'd0) && ((rxByte & `SWL_SYNC_MASK) != `SWL_SYNC_BYTE)) ||
                 ((rxIdx == 4'd1) && (rxByte != `SWL_MASTER_ADDR)) ||
                 ((rxIdx == 4'd2) && (rxByte != {1'b0, ctrlReg}));
  wire crcBad  = lastRx & (rxByte != crcAcc);
  wire tmo     = (state == swl_pkg::ST_LISTEN) & tick & (bitCnt >= waitLim);
  wire rxFail  = rxFrameErr | tmo | crcBad | (rxValid & hdrBad);
  wire sendEnd = (state == swl_pkg::ST_SEND) & txReady & (txIdx == txLen);

  // Status events
  wire evDone  = (sendEnd & ctrlWrite) | (lastRx & ~crcBad & ~hdrBad);
  wire [`SWL_ST_W-1:1] evSet = {divWrite & ~divOk, rxValid & hdrBad, tmo,
                                rxFrameErr, crcBad, evDone};
  wire [`SWL_ST_W-1:1] w1c   = (wrFire & hitStatus & wstrb[0]) ?
                               wdata[`SWL_ST_W-1:1] : '0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= swl_pkg::ST_IDLE;
      ctrlWrite <= 1'b0;
      ctrlNode <= '0;
      ctrlReg  <= '0;
      wdataReg <= '0;
      divReg   <= DEF_DIV[DIV_W-1:0];
      rtmoReg  <= `SWL_DEF_RTMO;
      status   <= '0;
      rdataReg <= '0;
      raddrReg <= '0;
      txIdx    <= '0;
      rxIdx    <= '0;
      crcAcc   <= '0;
      tickCnt  <= '0;
      bitCnt   <= '0;
      uartOut  <= 1'b1;
      uartOeN  <= 1'b1;
    end else begin
      status  <= (status & ~w1c) | evSet;
      uartOut <= txLine;
      tickCnt <= (tick || guardCl || rxStart) ? '0 : tickCnt + DIV_W'(1);
      if (guardCl || rxStart) begin
        bitCnt <= '0;
      end else if (tick) begin
        bitCnt <= bitCnt + 16'd1;
      end
      if (wrFire && hitCtrl && idle) begin
        ctrlWrite <= ctrlNew[`SWL_CTRL_WRITE];
        ctrlNode  <= ctrlNew[`SWL_CTRL_NODE_LSB +: 2];
        ctrlReg   <= ctrlNew[`SWL_CTRL_REG_LSB +: 7];
      end
      if (wrFire && hitWdata && idle) begin
        wdataReg <= merge(wdataReg, wdata, wstrb);
      end
      if (wrFire && hitRtmo) begin
        rtmoReg <= (rtmoNew[15:0] == 16'h0000) ? rtmoReg : rtmoNew[15:0];
      end
      if (divWrite && divOk) begin
        divReg <= divNew[DIV_W-1:0];
      end
      case (state)
        swl_pkg::ST_IDLE: begin
          if (goReq) begin
            state  <= swl_pkg::ST_GUARD;
            bitCnt <= '0;
            tickCnt <= '0;
          end
        end
        swl_pkg::ST_GUARD: begin
          if (tick && bitCnt == `SWL_IDLE_BITS - 16'd1) begin
            state   <= swl_pkg::ST_SEND;
            txIdx   <= '0;
            crcAcc  <= '0;
            uartOeN <= 1'b0;
          end
        end
        swl_pkg::ST_SEND: begin
          if (txGo) begin
            txIdx  <= txIdx + 4'd1;
            crcAcc <= crcStep(crcAcc, txByte);
          end
          if (sendEnd) begin
            uartOeN <= 1'b1;
            rxIdx   <= '0;
            crcAcc  <= '0;
            bitCnt  <= '0;
            state   <= ctrlWrite ? swl_pkg::ST_IDLE : swl_pkg::ST_LISTEN;
          end
        end
        swl_pkg::ST_LISTEN: begin
          if (rxValid) begin
            rxIdx  <= rxIdx + 4'd1;
            crcAcc <= crcStep(crcAcc, rxByte);
            if (rxIdx == 4'd2) begin
              raddrReg <= rxByte;
            end
            if (rxIdx >= 4'd3 && rxIdx <= 4'd6) begin
              rdataReg <= {rdataReg[23:0], rxByte};
            end
          end
          if (rxFail || lastRx) begin
            state <= swl_pkg::ST_IDLE;
          end
        end
        default: state <= swl_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : swl_host

// ### swl_host_sva.sv
// Port-level checks for the single-wire link host controller
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_host_sva (
  input wire logic        mclk,    // Clock
  input wire logic        arst_n,  // Reset, low
  input wire logic        bvalid,  // B valid
  input wire logic        bready,  // B ready
  input wire logic [1:0]  bresp,   // B code
  input wire logic        rvalid,  // R valid
  input wire logic        rready,  // R ready
  input wire logic [31:0] rdata,   // R data
  input wire logic [1:0]  rresp,   // R code
  input wire logic        uartOut, // Line level
  input wire logic        uartOeN  // Drive, low
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_fall; !uartOeN && $fell(uartOut); endsequence
  sequence s_rise; !uartOeN && $rose(uartOut); endsequence
  property p_low_bit; s_fall |-> !uartOut [*8]; endproperty
  a_low_bit: assert property (p_low_bit) else $error("Short low bit");
  property p_high_bit; s_rise |-> uartOut [*8]; endproperty
  a_high_bit: assert property (p_high_bit) else $error("Short high bit");
  property p_free; $rose(uartOeN) |-> $past(uartOut); endproperty
  a_free: assert property (p_free) else $error("Release without stop");
  property p_rst; $rose(arst_n) |-> uartOeN && !bvalid && !rvalid; endproperty
  a_rst: assert property (p_rst) else $error("Active after reset");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("B dropped");
  property p_rhold; rvalid && !rready |=> rvalid && $stable({rdata, rresp}); endproperty
  a_rhold: assert property (p_rhold) else $error("R dropped");
  property p_bcode; bvalid |-> bresp inside {`SWL_RESP_OKAY, `SWL_RESP_SLVERR}; endproperty
  a_bcode: assert property (p_bcode) else $error("Bad B code");
  property p_rcode; rvalid |-> rresp inside {`SWL_RESP_OKAY, `SWL_RESP_SLVERR}; endproperty
  a_rcode: assert property (p_rcode) else $error("Bad R code");
endmodule : swl_host_sva

// ### swl_dev_model.sv
// Behavioural register device on the far end of the single wire
`timescale 1ns/1ps
module swl_dev_model (
  input  wire logic       line,   // Bus level
  input  wire logic [1:0] node,   // Address pins
  input  wire logic       badCrc, // Spoil reply CRC
  output logic            devOut, // Driven level
  output logic            devOeN  // Drive, low
);
  logic [31:0] regs [128];
  logic [7:0]  b [8];
  logic [7:0]  cnt, c;
  logic        err;
  realtime     t, bt;
  int          len;
  function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] x);
    for (int i = 0; i < 8; i++) s = {s[6:0], 1'b0} ^ ((s[7] ^ x[i]) ? 8'h07 : 8'h00);
    return s;
  endfunction : crc8
  // Mid-bit samples, then the stop bit
  task automatic get(input int n, input int i0);
    for (int i = i0; i < 9; i++) begin
      #(t + (1.5 + i) * bt - $realtime);
      if (i < 8) b[n][i] = line;
      else err |= !line;
    end
  endtask : get
  task automatic put(input logic [7:0] x);
    logic [9:0] f;
    f = {1'b1, x, 1'b0};
    for (int i = 0; i < 10; i++) begin
      devOut = f[i];
      #bt;
    end
  endtask : put
  initial begin
    devOut = 1'b1;
    devOeN = 1'b1;
    cnt = 8'h00;
    foreach (regs[i]) regs[i] = 32'h0;
    forever begin
      @(negedge line);
      t = $realtime;
      err = 1'b0;
      len = 4;
      b[0] = 8'h05;
      repeat (2) @(negedge line);
      bt = ($realtime - t) / 4;
      get(0, 4);
      for (int n = 1; n < len && !err; n++) begin
        fork
          @(negedge line) t = $realtime;
          #(bt * 54) err = 1'b1;
        join_any
        disable fork;
        if (!err) get(n, 0);
        if (n == 2 && b[2][7]) len = 8;
      end
      c = 8'h00;
      for (int j = 0; j < len - 1; j++) c = crc8(c, b[j]);
      if (!err && c === b[len-1] && b[1] === {6'h0, node}) begin
        if (b[2][7]) begin
          regs[b[2][6:0]] = {b[3], b[4], b[5], b[6]};
          cnt++;
        end else begin
          {b[3], b[4], b[5], b[6]} = (b[2] == 8'h02) ? {24'h0, cnt} : regs[b[2][6:0]];
          b[1] = 8'hff;
          c = 8'h00;
          for (int j = 0; j < 7; j++) c = crc8(c, b[j]);
          b[7] = c ^ {7'h0, badCrc};
          #(bt * 8);
          devOeN = 1'b0;
          for (int j = 0; j < 8; j++) put(b[j]);
          #(bt * 4);
          devOeN = 1'b1;
        end
      end
    end
  end
endmodule : swl_dev_model

// ### swl_host_test.sv
// Self-checking bench for the single-wire link host controller
`timescale 1ns/1ps
`include "swl_params.svh"
module swl_host_test;
  logic        mclk = 1'b0, arst_n = 1'b0, badCrc = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, uartOut, uartOeN, devOut, devOeN;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, d, st;
  int          mismatches = 0, n_tests = 0, cyc = 0;
  // Pulled-up shared line
  wire         bus = (uartOeN === 1'b0) ? uartOut : (devOeN === 1'b0) ? devOut : 1'b1;
  always #12.5 mclk = ~mclk;
  swl_host #(.DEF_DIV(16'd40)) u_dut (.uartIn(bus), .*);
  swl_dev_model u_dev (.line(bus), .node(2'd1), .badCrc(badCrc), .devOut(devOut), .devOeN(devOeN));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic run_op(input logic w, input logic [1:0] nd, input logic [6:0] ix);
    axi_wr(`SWL_OFS_STATUS, 32'h7e);
    axi_wr(`SWL_OFS_CTRL, {9'h0, ix, 6'h0, nd, 6'h0, w, 1'b1});
    do axi_rd(`SWL_OFS_STATUS); while (d[`SWL_ST_BUSY] !== 1'b0);
    st = d;
  endtask : run_op
  task automatic t_regs;
    axi_rd(`SWL_OFS_DIV);
    chk("div", 32'd40, d);
    axi_rd(`SWL_OFS_RTMO);
    chk("rtmo", {16'h0, `SWL_DEF_RTMO}, d);
    axi_rd(8'h1c);
    chk("unmapped", {30'h0, `SWL_RESP_SLVERR}, {30'h0, rs});
    axi_wr(`SWL_OFS_DIV, 32'd8);
    axi_rd(`SWL_OFS_STATUS);
    chk("divrej", 32'h1, {31'h0, d[`SWL_ST_DIVREJ]});
    axi_rd(`SWL_OFS_DIV);
    chk("div kept", 32'd40, d);
    axi_wr(`SWL_OFS_STATUS, 32'h7e);
    chk("wr resp", {30'h0, `SWL_RESP_OKAY}, {30'h0, rs});
    axi_wr(`SWL_OFS_DIV, 32'd400);
    axi_rd(`SWL_OFS_STATUS);
    chk("slow div rej", 32'h1, {31'h0, d[`SWL_ST_DIVREJ]});
    axi_rd(`SWL_OFS_DIV);
    chk("slow div kept", 32'd40, d);
    axi_wr(8'h1c, 32'h0);
    chk("unmapped wr", {30'h0, `SWL_RESP_SLVERR}, {30'h0, rs});
  endtask : t_regs
  task automatic t_write;
    axi_wr(`SWL_OFS_WDATA, 32'ha5c30f81);
    run_op(1'b1, 2'd1, 7'h10);
    chk("wr status", 32'h2, st & 32'h1f);
    chk("wr reg", 32'ha5c30f81, u_dev.regs[16]);
    axi_wr(`SWL_OFS_WDATA, 32'h00000001);
    run_op(1'b1, 2'd1, 7'h7f);
    chk("wr top", 32'h1, u_dev.regs[127]);
    chk("wr count", 32'h2, {24'h0, u_dev.cnt});
  endtask : t_write
  task automatic t_read;
    axi_wr(`SWL_OFS_DIV, 32'd32);
    run_op(1'b0, 2'd1, 7'h10);
    axi_rd(`SWL_OFS_RDATA);
    chk("rd data", 32'ha5c30f81, d);
    chk("rd status", 32'h2, st & 32'h1f);
    axi_rd(`SWL_OFS_RADDR);
    chk("rd addr", 32'h10, d);
    repeat (2) begin
      run_op(1'b0, 2'd1, 7'h02);
      axi_rd(`SWL_OFS_RDATA);
      chk("counter", 32'h2, d);
    end
  endtask : t_read
  task automatic t_faults;
    badCrc <= 1'b1;
    run_op(1'b0, 2'd1, 7'h10);
    chk("crc flag", 32'h1, {31'h0, st[`SWL_ST_CRC]});
    badCrc <= 1'b0;
    axi_wr(`SWL_OFS_WDATA, 32'h12345678);
    run_op(1'b1, 2'd3, 7'h10);
    chk("other node", 32'ha5c30f81, u_dev.regs[16]);
    run_op(1'b0, 2'd2, 7'h10);
    chk("no reply", 32'h1, {31'h0, st[`SWL_ST_TMO]});
  endtask : t_faults
  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_write();
    t_read();
    t_faults();
    print_verdict();
  end
endmodule : swl_host_test
bind swl_host swl_host_sva u_sva (.*);
